// ---- core/mem_strobe_consts.svh ----
/*
 constants for the external memory strobe and mode entry block.
 assumes a 10 MHz system clock standing in for the oscillator.
*/
// How it works
// R1: while fetching from on-chip memory the program-store strobe stays high.
// R2: in external execution the program-store strobe pulses low twice per machine cycle.
// R3: an external data access drops two consecutive program-store pulses.
// R4: reset held high over 10 machine cycles plus a program-store fall enters host programming.
// R5: reset high for two machine cycles resets the device; the outside must hold it that long.
// R6: without a program-store fall during reset the device leaves reset into normal mode.
// R7: fetch-select tied low makes the device fetch code externally.
// R8: fetch-select tied high makes the device execute from on-chip memory.
// R9: external data writes drive the write strobe shared with a port pin.
// R10: external data reads drive the read strobe shared with a port pin.
// R11: the latch strobe pulses at a fixed fraction of the oscillator in normal operation.
// R12: each external data access skips exactly one latch strobe pulse.
// R13: the latch-strobe-off bit set to one disables the latch strobe.
// R14: in 6-clock mode the latch strobe runs at one third of the oscillator.
// R15: a machine cycle is twelve oscillator periods in standard mode.
`ifndef MEM_STROBE_CONSTS_SVH
`define MEM_STROBE_CONSTS_SVH
`define OSC_PER_MC_STD   12
`define OSC_PER_MC_FAST  6
`define RST_MIN_MC       2
`define HOSTPROG_MIN_MC  10
`endif

// ---- core/mem_strobe_pkg.sv ----
/*
 types for the external memory strobe block.
 assumes nothing beyond the constants header.
*/
package mem_strobe_pkg;
   typedef enum logic [1:0] {MODE_RESET, MODE_INTERNAL, MODE_EXTERNAL, MODE_HOSTPROG} op_mode_t;
   typedef enum logic [1:0] {XS_IDLE, XS_READ, XS_WRITE} xdata_state_t;
endpackage

// ---- core/pin_sync.sv ----
/*
 three-stage synchroniser; output changes once stages two and three agree.
 assumes an asynchronous pin input and one clock.
*/
`timescale 1ns/100ps
module pin_sync
#(
   parameter logic INIT = 1'b1
)
(
   input  wire logic sys_clk_i,
   input  wire logic rst_n_i,
   input  wire logic pin_i,
   output logic      level_o
);
   logic [2:0] stage;
   logic [2:0] next_stage;
   logic       next_level;

   always_comb
   begin
      next_stage = {stage[1:0], pin_i};
      next_level = (stage[1] == stage[2]) ? stage[2] : level_o;
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
      begin
         stage   <= {3{INIT}};
         level_o <= INIT;
      end
      else
      begin
         stage   <= next_stage;
         level_o <= next_level;
      end
   end
endmodule

// ---- core/ext_mem_strobes.sv ----
/*
 external memory strobes, reset filtering and mode entry.
 each sys_clk_i edge counts as one oscillator period; the core requests
 data accesses with xdata_rd_req_i / xdata_wr_req_i held until xdata_done_o.
*/
`timescale 1ns/100ps
`include "mem_strobe_consts.svh"
module ext_mem_strobes
   import mem_strobe_pkg::*;
#(
   parameter int RST_MC  = `RST_MIN_MC,
   parameter int PROG_MC = `HOSTPROG_MIN_MC
)
(
   input  wire logic sys_clk_i,
   input  wire logic rst_n_i,
   input  wire logic reset_pin_i,
   input  wire logic external_fetch_select_n_i,
   input  wire logic prog_strobe_pin_i,
   input  wire logic fast_clock_mode_i,
   input  wire logic latch_strobe_off_bit_i,
   input  wire logic xdata_rd_req_i,
   input  wire logic xdata_wr_req_i,
   output logic      program_store_strobe_n_o,
   output logic      prog_strobe_oe_o,
   output logic      addr_latch_strobe_o,
   output logic      data_read_strobe_n_o,
   output logic      data_write_strobe_n_o,
   output logic      xdata_done_o,
   output logic      core_reset_o,
   output op_mode_t  mode_o
);
   logic rst_lvl;
   logic fetch_sel_lvl;
   logic pstb_lvl;
   logic pstb_prev;
   logic [3:0] phase;
   logic [7:0] rst_cnt;
   logic       pstb_fell;
   xdata_state_t xs;
   xdata_state_t next_xs;
   logic [3:0] next_phase;
   logic [7:0] next_rst_cnt;
   logic       next_pstb_fell;
   op_mode_t   next_mode;
   logic       next_core_reset;
   logic       next_pstb;
   logic       next_poe;
   logic       next_ale;
   logic       next_rd;
   logic       next_wr;
   logic       next_done;
   logic [3:0] mc_len;
   logic       mc_end;
   logic       slot;

   pin_sync #(.INIT(1'b0)) u_rst  (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
                                   .pin_i(reset_pin_i), .level_o(rst_lvl));
   pin_sync #(.INIT(1'b1)) u_fsel (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
                                   .pin_i(external_fetch_select_n_i), .level_o(fetch_sel_lvl));
   pin_sync #(.INIT(1'b1)) u_pstb (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
                                   .pin_i(prog_strobe_pin_i), .level_o(pstb_lvl));

   // pulse slot: first half, rounded down, of each half machine cycle
   function automatic logic in_slot(input logic [3:0] ph, input logic [3:0] len);
      logic [3:0] half;
      half = len >> 1;
      return (ph < (half >> 1)) || ((ph >= half) && (ph < half + (half >> 1)));
   endfunction

   always_comb
   begin
      mc_len = fast_clock_mode_i ? 4'(`OSC_PER_MC_FAST) : 4'(`OSC_PER_MC_STD); // R14 R15
      // >= so that a shorter cycle picked mid-way wraps at once
      mc_end = (phase >= mc_len - 4'h1);
      slot   = in_slot(phase, mc_len);
      next_phase = mc_end ? 4'h0 : phase + 4'h1;
      next_pstb_fell = pstb_fell;
      next_rst_cnt = rst_cnt;
      next_mode = mode_o;
      next_core_reset = core_reset_o;
      if (rst_lvl)
      begin
         if (pstb_prev && !pstb_lvl && rst_cnt >= 8'(PROG_MC))
            next_pstb_fell = 1'b1; // R4
         if (mc_end && rst_cnt != 8'hff)
            next_rst_cnt = rst_cnt + 8'h01;
         if (rst_cnt >= 8'(RST_MC))
         begin
            next_core_reset = 1'b1; // R5
            next_mode = MODE_RESET;
         end
      end
      else
      begin
         next_rst_cnt = 8'h00;
         next_pstb_fell = 1'b0;
         // block reset alone never lets go: a qualified pin reset comes first
         if (core_reset_o && rst_cnt >= 8'(RST_MC))
         begin
            next_core_reset = 1'b0;
            if (pstb_fell)
               next_mode = MODE_HOSTPROG; // R4
            else
               next_mode = fetch_sel_lvl ? MODE_INTERNAL : MODE_EXTERNAL; // R6 R7 R8
         end
      end
      next_xs = xs;
      next_done = 1'b0;
      if (mc_end)
      begin
         case (xs)
            XS_IDLE:
               if (xdata_wr_req_i && !xdata_done_o)
                  next_xs = XS_WRITE;
               else if (xdata_rd_req_i && !xdata_done_o)
                  next_xs = XS_READ;
            XS_READ, XS_WRITE:
            begin
               next_xs = XS_IDLE;
               next_done = 1'b1;
            end
            default: next_xs = XS_IDLE;
         endcase
      end
      if (core_reset_o || mode_o == MODE_RESET)
         next_xs = XS_IDLE;
      // R1 R2 R3: pulses only outside a data cycle
      next_pstb = !((mode_o == MODE_EXTERNAL) && slot && (xs == XS_IDLE));
      next_poe = (mode_o == MODE_EXTERNAL) || (mode_o == MODE_INTERNAL);
      // R11 R12 R13: two pulses per machine cycle, first-half one dropped in data cycle
      next_ale = !latch_strobe_off_bit_i && (mode_o == MODE_INTERNAL || mode_o == MODE_EXTERNAL)
                 && slot && !((xs != XS_IDLE) && phase < (mc_len >> 1));
      next_rd = !((xs == XS_READ) && phase >= 4'h1 && !mc_end); // R10
      next_wr = !((xs == XS_WRITE) && phase >= 4'h1 && !mc_end); // R9
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
      begin
         phase <= 4'h0;
         rst_cnt <= 8'h00;
         pstb_fell <= 1'b0;
         pstb_prev <= 1'b1;
         xs <= XS_IDLE;
         mode_o <= MODE_RESET;
         core_reset_o <= 1'b1;
         program_store_strobe_n_o <= 1'b1;
         prog_strobe_oe_o <= 1'b0;
         addr_latch_strobe_o <= 1'b0;
         data_read_strobe_n_o <= 1'b1;
         data_write_strobe_n_o <= 1'b1;
         xdata_done_o <= 1'b0;
      end
      else
      begin
         phase <= next_phase;
         rst_cnt <= next_rst_cnt;
         pstb_fell <= next_pstb_fell;
         pstb_prev <= pstb_lvl;
         xs <= next_xs;
         mode_o <= next_mode;
         core_reset_o <= next_core_reset;
         program_store_strobe_n_o <= next_pstb;
         prog_strobe_oe_o <= next_poe;
         addr_latch_strobe_o <= next_ale;
         data_read_strobe_n_o <= next_rd;
         data_write_strobe_n_o <= next_wr;
         xdata_done_o <= next_done;
      end
   end

   property p_int_high;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (mode_o == MODE_INTERNAL) |=> program_store_strobe_n_o;
   endproperty
   a_int_high: assert property (p_int_high) else $error("strobe low in internal mode"); // R1

   property p_no_pstb_in_xdata;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (xs != XS_IDLE) |=> program_store_strobe_n_o;
   endproperty
   a_no_pstb_in_xdata: assert property (p_no_pstb_in_xdata) else $error("strobe in data cycle"); // R3

   property p_ext_pulses;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (mode_o == MODE_EXTERNAL && xs == XS_IDLE && phase == 4'h0 && !fast_clock_mode_i
       && $stable(mode_o)) |=> !program_store_strobe_n_o;
   endproperty
   a_ext_pulses: assert property (p_ext_pulses) else $error("missing program strobe"); // R2

   property p_ale_off;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      latch_strobe_off_bit_i |=> !addr_latch_strobe_o;
   endproperty
   a_ale_off: assert property (p_ale_off) else $error("latch strobe while disabled"); // R13

   property p_rd_only_read;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      !data_read_strobe_n_o |-> $past(xs) == XS_READ && data_write_strobe_n_o;
   endproperty
   a_rd_only_read: assert property (p_rd_only_read) else $error("read strobe outside read"); // R10

   property p_wr_only_write;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      !data_write_strobe_n_o |-> $past(xs) == XS_WRITE;
   endproperty
   a_wr_only_write: assert property (p_wr_only_write) else $error("write strobe outside write"); // R9

   property p_reset_after_two;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (rst_lvl && rst_cnt >= 8'(RST_MC)) |=> core_reset_o;
   endproperty
   a_reset_after_two: assert property (p_reset_after_two) else $error("reset not taken"); // R5

   property p_normal_exit;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (core_reset_o && !rst_lvl && !pstb_fell) |=> mode_o != MODE_HOSTPROG;
   endproperty
   a_normal_exit: assert property (p_normal_exit) else $error("host mode without fall"); // R6

   property p_hostprog;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (core_reset_o && !rst_lvl && pstb_fell) |=> mode_o == MODE_HOSTPROG;
   endproperty
   a_hostprog: assert property (p_hostprog) else $error("host mode not entered"); // R4
endmodule

// ---- tb/ext_mem_model.sv ----
/*
 behavioural external program and data memory; counts strobe activity.
 assumes the strobes are sampled on the one system clock.
*/
`timescale 1ns/100ps
module ext_mem_model
(
   input  wire logic       sys_clk_i,
   input  wire logic       prog_wire_i,
   input  wire logic       ale_i,
   input  wire logic       rd_n_i,
   input  wire logic       wr_n_i,
   output logic [7:0]      fetch_cnt_o,
   output logic [7:0]      latch_cnt_o,
   output logic [7:0]      rd_cnt_o,
   output logic [7:0]      wr_cnt_o
);
   logic       prog_d    = 1'b1;
   logic       ale_d     = 1'b0;
   logic [7:0] fetch_cnt = 8'h00;
   logic [7:0] latch_cnt = 8'h00;
   logic [7:0] rd_cnt    = 8'h00;
   logic [7:0] wr_cnt    = 8'h00;
   assign fetch_cnt_o = fetch_cnt;
   assign latch_cnt_o = latch_cnt;
   assign rd_cnt_o    = rd_cnt;
   assign wr_cnt_o    = wr_cnt;
   // program and latch strobes counted by edge, data strobes by low cycle
   always @(posedge sys_clk_i)
   begin
      prog_d <= prog_wire_i;
      ale_d  <= ale_i;
      if (prog_d && !prog_wire_i) fetch_cnt <= fetch_cnt + 8'h01;
      if (!ale_d && ale_i) latch_cnt <= latch_cnt + 8'h01;
      if (!rd_n_i) rd_cnt <= rd_cnt + 8'h01;
      if (!wr_n_i) wr_cnt <= wr_cnt + 8'h01;
   end
endmodule

// ---- tb/ext_mem_strobes_tb_top.sv ----
/*
 testbench: mode entry, strobe rates and data accesses.
 assumes the memory model in ext_mem_model.sv and the design under core/.
*/
`timescale 1ns/100ps
module ext_mem_strobes_tb_top;
   import mem_strobe_pkg::*;
   logic sys_clk_i = 1'b0, rst_n_i = 1'b0, reset_pin = 1'b1, fsel_n = 1'b1;
   logic host_prog = 1'b1, fast = 1'b0, lso = 1'b0, rd_req = 1'b0, wr_req = 1'b0;
   logic pstb_n, oe, ale, rd_n, wr_n, done, core_rst, prog_wire;
   logic [7:0] fc, lc, rc, wc;
   op_mode_t   mode;
   int         error_cnt = 0, num_checks = 0, cyc = 0;
   // host drives the pin only while the device lets go of it
   assign prog_wire = oe ? pstb_n : host_prog;
   ext_mem_strobes uut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reset_pin_i(reset_pin),
      .external_fetch_select_n_i(fsel_n), .prog_strobe_pin_i(prog_wire),
      .fast_clock_mode_i(fast), .latch_strobe_off_bit_i(lso), .xdata_rd_req_i(rd_req),
      .xdata_wr_req_i(wr_req), .program_store_strobe_n_o(pstb_n), .prog_strobe_oe_o(oe),
      .addr_latch_strobe_o(ale), .data_read_strobe_n_o(rd_n), .data_write_strobe_n_o(wr_n),
      .xdata_done_o(done), .core_reset_o(core_rst), .mode_o(mode));
   ext_mem_model mem (.sys_clk_i(sys_clk_i), .prog_wire_i(prog_wire), .ale_i(ale),
      .rd_n_i(rd_n), .wr_n_i(wr_n), .fetch_cnt_o(fc), .latch_cnt_o(lc),
      .rd_cnt_o(rc), .wr_cnt_o(wc));
   initial
   begin
      forever #50 sys_clk_i = ~sys_clk_i;
   end
   task automatic print_verdict();
      if (error_cnt == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   always @(posedge sys_clk_i)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         error_cnt++;
         print_verdict();
      end
   end
   task automatic check_cnt(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("ERROR t=%0t count %0d expected %0d", $time, got, exp);
      end
   endtask
   task automatic check_mode(input op_mode_t got, input op_mode_t exp);
      num_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("ERROR t=%0t mode %0d expected %0d", $time, got, exp);
      end
   endtask
   task automatic enter(input logic fsel, input int hold_mc, input logic fall, input op_mode_t m);
      int k;
      rst_n_i <= 1'b0;
      reset_pin <= 1'b1;
      fsel_n <= fsel;
      host_prog <= 1'b1;
      repeat (8) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      repeat (4) @(posedge sys_clk_i);
      check_mode(mode, MODE_RESET);
      repeat (hold_mc * 12 - 4) @(posedge sys_clk_i);
      if (fall)
      begin
         host_prog <= 1'b0;
         repeat (12) @(posedge sys_clk_i);
      end
      reset_pin <= 1'b0;
      for (k = 0; k < 100 && core_rst !== 1'b0; k++) @(posedge sys_clk_i);
      repeat (4) @(posedge sys_clk_i);
      host_prog <= 1'b1;
      check_mode(mode, m);
   endtask
   task automatic t_rates();
      logic [7:0] f0, l0;
      f0 = fc;
      l0 = lc;
      repeat (36) @(posedge sys_clk_i);
      check_cnt(fc - f0, 8'h06);
      check_cnt(lc - l0, 8'h06);
      lso <= 1'b1;
      repeat (12) @(posedge sys_clk_i);
      l0 = lc;
      repeat (24) @(posedge sys_clk_i);
      check_cnt(lc - l0, 8'h00);
      lso <= 1'b0;
      fast <= 1'b1;
      repeat (12) @(posedge sys_clk_i);
      l0 = lc;
      repeat (12) @(posedge sys_clk_i);
      check_cnt(lc - l0, 8'h04);
      fast <= 1'b0;
      repeat (12) @(posedge sys_clk_i);
   endtask
   task automatic t_access(input logic wr);
      int k;
      logic [7:0] f0, l0, r0, w0;
      f0 = fc;
      l0 = lc;
      r0 = rc;
      w0 = wc;
      if (wr) wr_req <= 1'b1;
      else rd_req <= 1'b1;
      for (k = 0; k < 40 && done !== 1'b1; k++) @(posedge sys_clk_i);
      rd_req <= 1'b0;
      wr_req <= 1'b0;
      repeat (36 - k) @(posedge sys_clk_i);
      check_cnt(fc - f0, 8'h04);
      check_cnt(lc - l0, 8'h05);
      check_cnt(rc - r0, wr ? 8'h00 : 8'h0a);
      check_cnt(wc - w0, wr ? 8'h0a : 8'h00);
   endtask
   task automatic t_internal();
      logic [7:0] f0;
      enter(1'b1, 3, 1'b0, MODE_INTERNAL);
      f0 = fc;
      repeat (48) @(posedge sys_clk_i);
      check_cnt(fc - f0, 8'h00);
   endtask
   initial
   begin
      enter(1'b0, 3, 1'b0, MODE_EXTERNAL);
      t_rates();
      t_access(1'b0);
      t_access(1'b1);
      t_internal();
      enter(1'b0, 12, 1'b1, MODE_HOSTPROG);
      print_verdict();
   end
endmodule
